// >>> core/tpgm_pkg.sv
/*
 * Package for the triggered pulse generator and pulse-modulation control block:
 * APB register offsets, field positions, reset values, modes and states.
 * Assumes a 20 MHz reference clock and 32-bit APB data.
 */
package tpgm_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_PERIOD    = 8'h04;
    localparam logic [7:0]  ADDR_WIDTH     = 8'h08;
    localparam logic [7:0]  ADDR_DELAY     = 8'h0C;
    localparam logic [7:0]  ADDR_DBL_DELAY = 8'h10;
    localparam logic [7:0]  ADDR_CMD       = 8'h14;
    localparam logic [7:0]  ADDR_STATUS    = 8'h18;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int CTRL_SRC_LO   = 0;
    localparam int CTRL_POL_BIT  = 2;
    localparam int CTRL_DBL_BIT  = 3;
    localparam int CTRL_TRG_LO   = 4;
    localparam int CTRL_SLOPE    = 6;
    localparam int CTRL_GATE_POL = 7;
    localparam int CMD_FIRE_BIT  = 0;

    localparam int CNT_W = 24;

    // Preset: 10 us period, 1 us width, 0.05 us delay at 50 ns -> 200, 20, 1
    localparam logic [23:0] RST_PERIOD    = 24'h0000C8;
    localparam logic [23:0] RST_WIDTH     = 24'h000014;
    localparam logic [23:0] RST_DELAY     = 24'h000001;
    localparam logic [23:0] RST_DBL_DELAY = 24'h000014;
    localparam logic [23:0] CNT_ONE       = 24'h000001;

    typedef enum logic [1:0] {
        TPGM_SRC_OFF = 2'h0,
        TPGM_SRC_EXT = 2'h1,
        TPGM_SRC_GEN = 2'h2
    } tpgm_src_t;

    typedef enum logic [1:0] {
        TPGM_TRG_AUTO   = 2'h0,
        TPGM_TRG_SINGLE = 2'h1,
        TPGM_TRG_EXT    = 2'h2,
        TPGM_TRG_GATED  = 2'h3
    } tpgm_trg_t;

    // Gray steps: idle -> delay -> pulse -> gap -> second pulse; pulse and second pulse return to idle
    typedef enum logic [2:0] {
        TPGM_ST_IDLE  = 3'h0,
        TPGM_ST_DELAY = 3'h1,
        TPGM_ST_PULSE = 3'h3,
        TPGM_ST_GAP   = 3'h2,
        TPGM_ST_PULS2 = 3'h6
    } tpgm_state_t;

    typedef struct packed {
        tpgm_src_t src;
        logic      pol_inv;
        logic      dbl_en;
        tpgm_trg_t trg;
        logic      slope_neg;
        logic      gate_inv;
    } tpgm_ctrl_t;

    typedef struct packed {
        logic [23:0] period;
        logic [23:0] width;
        logic [23:0] delay;
        logic [23:0] dbl_delay;
    } tpgm_timing_t;

endpackage : tpgm_pkg

// >>> core/tpgm_core.sv
/*
 * Triggered pulse generator with pulse-modulation source and polarity control.
 * APB slave for settings, one 20 MHz reference clock, synchronous active-low reset.
 * Assumes ext_in is asynchronous to clk; rf_gate feeds the RF on/off switch.
 */
`timescale 1ns/1ps

module tpgm_core #(
    parameter int CNT_W = tpgm_pkg::CNT_W
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_in,
    output logic             rf_gate,
    output logic             pulse_mon
);

    // ------------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------------
    tpgm_pkg::tpgm_ctrl_t   ctrl_ff;
    tpgm_pkg::tpgm_timing_t tim_ff;
    logic                   fire_ff;
    logic                   wr_en;
    logic                   rd_en;
    logic                   addr_ok;
    logic [7:0]             ctrl_rd;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;   // Load in setup so data stands at access
    assign pready  = 1'b1;                      // Zero-wait slave
    assign addr_ok = (paddr == tpgm_pkg::ADDR_CTRL)   || (paddr == tpgm_pkg::ADDR_PERIOD)
                  || (paddr == tpgm_pkg::ADDR_WIDTH)  || (paddr == tpgm_pkg::ADDR_DELAY)
                  || (paddr == tpgm_pkg::ADDR_DBL_DELAY) || (paddr == tpgm_pkg::ADDR_CMD)
                  || (paddr == tpgm_pkg::ADDR_STATUS);
    assign pslverr = psel && penable && !addr_ok;

    // Readback in write order; the struct packs its fields the other way
    assign ctrl_rd = {ctrl_ff.gate_inv, ctrl_ff.slope_neg, ctrl_ff.trg,
                      ctrl_ff.dbl_en, ctrl_ff.pol_inv, ctrl_ff.src};

    // Control register write
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_ff <= '{src: tpgm_pkg::TPGM_SRC_OFF, pol_inv: 1'b0, dbl_en: 1'b0,
                         trg: tpgm_pkg::TPGM_TRG_SINGLE, slope_neg: 1'b0, gate_inv: 1'b0};
        end else if (wr_en && paddr == tpgm_pkg::ADDR_CTRL) begin
            ctrl_ff.src       <= tpgm_pkg::tpgm_src_t'(pwdata[tpgm_pkg::CTRL_SRC_LO +: 2]);
            ctrl_ff.pol_inv   <= pwdata[tpgm_pkg::CTRL_POL_BIT];
            ctrl_ff.dbl_en    <= pwdata[tpgm_pkg::CTRL_DBL_BIT];
            ctrl_ff.trg       <= tpgm_pkg::tpgm_trg_t'(pwdata[tpgm_pkg::CTRL_TRG_LO +: 2]);
            ctrl_ff.slope_neg <= pwdata[tpgm_pkg::CTRL_SLOPE];
            ctrl_ff.gate_inv  <= pwdata[tpgm_pkg::CTRL_GATE_POL];
        end
    end

    // Timing registers; a zero period, width or pair delay is raised to one so counters never stall
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tim_ff <= '{period: tpgm_pkg::RST_PERIOD, width: tpgm_pkg::RST_WIDTH,
                        delay: tpgm_pkg::RST_DELAY, dbl_delay: tpgm_pkg::RST_DBL_DELAY};
        end else if (wr_en) begin
            case (paddr)
                tpgm_pkg::ADDR_PERIOD:    tim_ff.period    <= (pwdata[23:0] == '0) ? tpgm_pkg::CNT_ONE
                                                                                     : pwdata[23:0];
                tpgm_pkg::ADDR_WIDTH:     tim_ff.width     <= (pwdata[23:0] == '0) ? tpgm_pkg::CNT_ONE
                                                                                     : pwdata[23:0];
                tpgm_pkg::ADDR_DELAY:     tim_ff.delay     <= pwdata[23:0];
                tpgm_pkg::ADDR_DBL_DELAY: tim_ff.dbl_delay <= (pwdata[23:0] == '0) ? tpgm_pkg::CNT_ONE
                                                                                     : pwdata[23:0];
                default: ;
            endcase
        end
    end

    // Single-pulse command: one-cycle pulse, accepted only in manual mode
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fire_ff <= 1'b0;
        end else begin
            fire_ff <= wr_en && (paddr == tpgm_pkg::ADDR_CMD) && pwdata[tpgm_pkg::CMD_FIRE_BIT]
                    && (ctrl_ff.trg == tpgm_pkg::TPGM_TRG_SINGLE);
        end
    end

    // ------------------------------------------------------------------
    // External input synchroniser and edge detect
    // ------------------------------------------------------------------
    logic ext_s1_ff;
    logic ext_s2_ff;
    logic ext_s3_ff;
    logic ext_edge;
    logic gate_act;

    // Two flops against metastability, third only for edge history
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_in;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    assign ext_edge = ctrl_ff.slope_neg ? (ext_s3_ff && !ext_s2_ff)
                                        : (!ext_s3_ff && ext_s2_ff);
    assign gate_act = ext_s2_ff ^ ctrl_ff.gate_inv;

    // ------------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] per_cnt_ff;
    logic             per_tick;
    logic             trig;

    // Repetition counter on the reference clock; runs in auto and gated modes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            per_cnt_ff <= '0;
        end else if ((ctrl_ff.trg == tpgm_pkg::TPGM_TRG_AUTO)
                  || (ctrl_ff.trg == tpgm_pkg::TPGM_TRG_GATED && gate_act)) begin
            per_cnt_ff <= per_tick ? '0 : per_cnt_ff + 1'b1;
        end else begin
            per_cnt_ff <= '0;                                  // Gate restarts in phase
        end
    end

    assign per_tick = (per_cnt_ff == tim_ff.period - 1'b1);

    // Each mode offers its own trigger source
    always_comb begin
        case (ctrl_ff.trg)
            tpgm_pkg::TPGM_TRG_AUTO:   trig = per_tick;
            tpgm_pkg::TPGM_TRG_SINGLE: trig = fire_ff;
            tpgm_pkg::TPGM_TRG_EXT:    trig = ext_edge;
            tpgm_pkg::TPGM_TRG_GATED:  trig = gate_act && per_tick;
            default:                   trig = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Pulse sequencer
    // ------------------------------------------------------------------
    tpgm_pkg::tpgm_state_t st_ff;
    logic [CNT_W-1:0]      tmr_ff;
    logic                  pulse_ff;

    // A trigger arriving mid-sequence is dropped: the shape is never truncated
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff  <= tpgm_pkg::TPGM_ST_IDLE;
            tmr_ff <= '0;
        end else begin
            case (st_ff)
                tpgm_pkg::TPGM_ST_IDLE: begin
                    if (trig && !ctrl_ff.dbl_en && tim_ff.delay != '0) begin
                        st_ff  <= tpgm_pkg::TPGM_ST_DELAY;
                        tmr_ff <= tim_ff.delay - 1'b1;
                    end else if (trig) begin
                        st_ff  <= tpgm_pkg::TPGM_ST_PULSE;
                        tmr_ff <= tim_ff.width - 1'b1;
                    end
                end
                tpgm_pkg::TPGM_ST_DELAY: begin
                    if (tmr_ff == '0) begin
                        st_ff  <= tpgm_pkg::TPGM_ST_PULSE;
                        tmr_ff <= tim_ff.width - 1'b1;
                    end else begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end
                end
                tpgm_pkg::TPGM_ST_PULSE: begin
                    if (tmr_ff != '0) begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end else if (ctrl_ff.dbl_en) begin
                        st_ff  <= tpgm_pkg::TPGM_ST_GAP;
                        tmr_ff <= tim_ff.dbl_delay - 1'b1;
                    end else begin
                        st_ff  <= tpgm_pkg::TPGM_ST_IDLE;
                    end
                end
                tpgm_pkg::TPGM_ST_GAP: begin
                    if (tmr_ff == '0) begin
                        st_ff  <= tpgm_pkg::TPGM_ST_PULS2;
                        tmr_ff <= tim_ff.width - 1'b1;
                    end else begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end
                end
                tpgm_pkg::TPGM_ST_PULS2: begin
                    if (tmr_ff == '0) begin
                        st_ff <= tpgm_pkg::TPGM_ST_IDLE;
                    end else begin
                        tmr_ff <= tmr_ff - 1'b1;
                    end
                end
                default: st_ff <= tpgm_pkg::TPGM_ST_IDLE;
            endcase
        end
    end

    // Registered pulse level, one cycle behind the state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= (st_ff == tpgm_pkg::TPGM_ST_PULSE) || (st_ff == tpgm_pkg::TPGM_ST_PULS2);
        end
    end

    // ------------------------------------------------------------------
    // RF gate and monitor outputs
    // ------------------------------------------------------------------
    logic ctl_lvl;
    logic gate_ff;
    logic mon_ff;

    // Source choice never stops the generator, it only picks the control level
    always_comb begin
        case (ctrl_ff.src)
            tpgm_pkg::TPGM_SRC_EXT: ctl_lvl = ext_s2_ff;
            tpgm_pkg::TPGM_SRC_GEN: ctl_lvl = pulse_ff;
            default:                ctl_lvl = 1'b0;
        endcase
    end

    // Off leaves RF unmodulated (gate held on) regardless of polarity
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gate_ff <= 1'b1;
            mon_ff  <= 1'b0;
        end else begin
            if (ctrl_ff.src == tpgm_pkg::TPGM_SRC_OFF) begin
                gate_ff <= 1'b1;
            end else begin
                gate_ff <= ctl_lvl ^ ctrl_ff.pol_inv;
            end
            mon_ff <= pulse_ff;
        end
    end

    assign rf_gate   = gate_ff;
    assign pulse_mon = mon_ff;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (rd_en) begin
            case (paddr)
                tpgm_pkg::ADDR_CTRL:      prdata <= {24'h000000, ctrl_rd};
                tpgm_pkg::ADDR_PERIOD:    prdata <= {8'h00, tim_ff.period};
                tpgm_pkg::ADDR_WIDTH:     prdata <= {8'h00, tim_ff.width};
                tpgm_pkg::ADDR_DELAY:     prdata <= {8'h00, tim_ff.delay};
                tpgm_pkg::ADDR_DBL_DELAY: prdata <= {8'h00, tim_ff.dbl_delay};
                tpgm_pkg::ADDR_STATUS:    prdata <= {27'h0000000, gate_act, pulse_ff, st_ff};
                default:                  prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_ONE_L = CNT_W'(tpgm_pkg::CNT_ONE);

    sequence s_pulse_rise;
        !pulse_ff ##1 pulse_ff;
    endsequence

    AST_SRC_OFF: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.src == tpgm_pkg::TPGM_SRC_OFF |=> rf_gate)
        else $error("gate not held on with source off");
    AST_EXT_PASS: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.src == tpgm_pkg::TPGM_SRC_EXT && !ctrl_ff.pol_inv && $stable(ctrl_ff) |=> rf_gate == $past(ext_s2_ff))
        else $error("external level not passed to gate");
    AST_GEN_PASS: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.src == tpgm_pkg::TPGM_SRC_GEN && !ctrl_ff.pol_inv && $stable(ctrl_ff) |=> rf_gate == $past(pulse_ff))
        else $error("generator pulse not on gate");
    AST_POL_INV: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.src == tpgm_pkg::TPGM_SRC_GEN && ctrl_ff.pol_inv && $stable(ctrl_ff) |=> rf_gate == !$past(pulse_ff))
        else $error("inverse polarity not applied");
    AST_MON: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> pulse_mon == $past(pulse_ff))
        else $error("monitor does not follow pulse");
    AST_FIRE_IGN: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.trg != tpgm_pkg::TPGM_TRG_SINGLE |=> !fire_ff)
        else $error("single command acted on outside manual mode");
    AST_WIDTH_ONE: assert property (@(posedge clk) disable iff (!rstn)
        s_pulse_rise ##0 (tim_ff.width == CNT_ONE_L) |=> !pulse_ff)
        else $error("pulse of width one too long");
    AST_SINGLE_GO: assert property (@(posedge clk) disable iff (!rstn)
        fire_ff && st_ff == tpgm_pkg::TPGM_ST_IDLE && (ctrl_ff.dbl_en || tim_ff.delay == '0) |=> ##1 pulse_ff)
        else $error("manual command gave no pulse");
    AST_GATE_STOP: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.trg == tpgm_pkg::TPGM_TRG_GATED && !gate_act |-> !trig ##1 per_cnt_ff == '0)
        else $error("trigger or count while gate inactive");

    // Starts: the single delay belongs to single mode only
    sequence s_start_single;
        st_ff == tpgm_pkg::TPGM_ST_IDLE && trig && !ctrl_ff.dbl_en;
    endsequence

    sequence s_start_double;
        st_ff == tpgm_pkg::TPGM_ST_IDLE && trig && ctrl_ff.dbl_en;
    endsequence

    AST_DELAY_FIRST: assert property (@(posedge clk) disable iff (!rstn)
        s_start_single ##0 (tim_ff.delay != '0) |=> st_ff == tpgm_pkg::TPGM_ST_DELAY)
        else $error("single pulse skipped its delay");
    AST_DBL_NO_DELAY: assert property (@(posedge clk) disable iff (!rstn)
        s_start_double |=> st_ff == tpgm_pkg::TPGM_ST_PULSE)
        else $error("double pulse waited for the single delay");

    // First pulse ends: idle when single, a low gap when double
    AST_SINGLE_END: assert property (@(posedge clk) disable iff (!rstn)
        st_ff == tpgm_pkg::TPGM_ST_PULSE && tmr_ff == '0 && !ctrl_ff.dbl_en |=> st_ff == tpgm_pkg::TPGM_ST_IDLE)
        else $error("single mode went on past its pulse");
    AST_PAIR_GAP: assert property (@(posedge clk) disable iff (!rstn)
        st_ff == tpgm_pkg::TPGM_ST_PULSE && tmr_ff == '0 && ctrl_ff.dbl_en
        |=> st_ff == tpgm_pkg::TPGM_ST_GAP ##1 !pulse_ff)
        else $error("pair pulses not separated by a gap");

    // External edges, judged on the synchronised level
    AST_EDGE_SLOPE: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.trg == tpgm_pkg::TPGM_TRG_EXT && (ctrl_ff.slope_neg ? $fell(ext_s2_ff) : $rose(ext_s2_ff)) |-> trig)
        else $error("active external edge gave no trigger");
    AST_EDGE_WRONG: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.trg == tpgm_pkg::TPGM_TRG_EXT && (ctrl_ff.slope_neg ? $rose(ext_s2_ff) : $fell(ext_s2_ff)) |-> !trig)
        else $error("trigger on the inactive external edge");

    // In auto mode the timebase counts every reference cycle and starts the generator whatever the source
    AST_AUTO_COUNT: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.trg == tpgm_pkg::TPGM_TRG_AUTO && !per_tick |=> per_cnt_ff == $past(per_cnt_ff) + 1'b1)
        else $error("timebase skipped a reference cycle");
    AST_AUTO_RUN: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff.trg == tpgm_pkg::TPGM_TRG_AUTO && per_tick && st_ff == tpgm_pkg::TPGM_ST_IDLE
        |=> st_ff != tpgm_pkg::TPGM_ST_IDLE)
        else $error("timebase tick did not start the generator");

endmodule : tpgm_core

// >>> verif/tpgm_ext_src.sv
/*
 * Far-side model: external trigger, gate and modulation source on ext_in,
 * plus the RF modulator that counts the cycles its gate keeps RF on.
 * Assumes the bench clock; the block treats ext_in as asynchronous.
 */
`timescale 1ns/1ps

module tpgm_ext_src (
    input  wire logic clk,
    input  wire logic rf_gate,
    output logic      ext_in
);
    int rf_on_cnt;  // RF-on cycles seen by the modulator

    // ------------------------------------------------------------------
    // Modulator side
    // ------------------------------------------------------------------
    initial begin
        ext_in    = 1'b0;
        rf_on_cnt = 0;
    end

    // Counts envelope cycles, only a clean high counts as RF on
    always @(posedge clk) begin
        if (rf_gate === 1'b1) begin
            rf_on_cnt <= rf_on_cnt + 1;
        end
    end

    // ------------------------------------------------------------------
    // Source side
    // ------------------------------------------------------------------
    // Holds one level for n cycles, changed just after an edge
    task automatic hold(input logic v, input int n);
        ext_in <= v;
        repeat (n) @(posedge clk);
    endtask : hold

    // Whole pulses, spaced well beyond one sequence so none is dropped
    task automatic edges(input int n);
        for (int i = 0; i < n; i++) begin
            hold(1'b1, 30 + int'($urandom % 20));
            hold(1'b0, 30 + int'($urandom % 20));
        end
    endtask : edges
endmodule : tpgm_ext_src

// >>> verif/tpgm_core_tb_top.sv
/*
 * Self-checking bench for tpgm_core: APB master, pulse monitor with queues,
 * and expectations worked out from the programmed counts in cycles.
 * Assumes pready answers within the watchdog span.
 */
`timescale 1ns/1ps

module tpgm_core_tb_top;
    localparam logic [31:0] RST_TAB [5] = '{32'h10, 32'hC8, 32'h14, 32'h1, 32'h14};

    logic        clk, rstn, psel, penable, pwrite, pm_d, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, ext_in, rf_gate, pulse_mon;
    int          err_count, n_checks, cyc, run, wcyc, w, d, g, p, lat0, lat, n, n0, c0;
    int          rises[$];
    int          widths[$];

    tpgm_core tpgm_core_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_in(ext_in), .rf_gate(rf_gate), .pulse_mon(pulse_mon));
    tpgm_ext_src tpgm_ext_src_i (.clk(clk), .rf_gate(rf_gate), .ext_in(ext_in));

    // ------------------------------------------------------------------
    // Clock, monitor, watchdog
    // ------------------------------------------------------------------
    always #25 clk = ~clk;

    // Rise cycles and widths of the monitor pulse, in clock cycles
    always @(posedge clk) begin
        cyc  <= cyc + 1;
        pm_d <= (pulse_mon === 1'b1);
        run  <= (pulse_mon === 1'b1) ? run + 1 : 0;
        if (pulse_mon === 1'b1 && !pm_d) begin
            rises.push_back(cyc);
        end
        if (pulse_mon !== 1'b1 && pm_d) begin
            widths.push_back(run);
        end
    end

    // Cuts a hang short; the whole run needs far fewer cycles
    initial begin
        #(50 * 40000);
        err_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer; an idle edge follows so psel is never set twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd      = prdata;
        er      = pslverr;
        wcyc    = cyc;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Software single pulse; returns rise latency of its first pulse and pulse count
    task automatic fire(output int l, output int k);
        int nb;
        nb = rises.size();
        apb(1'b1, tpgm_pkg::ADDR_CMD, 32'h1);
        repeat (60) @(posedge clk);
        k = rises.size() - nb;
        l = (k > 0) ? rises[nb] - wcyc : -1;
    endtask : fire

    // RF gate against the generated pulse over k cycles
    task automatic cmp_rf(input logic inv, input int k);
        repeat (k) begin
            @(posedge clk);
            check(rf_gate, pulse_mon ^ inv);
        end
    endtask : cmp_rf

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
        err_count = 0; n_checks = 0; cyc = 0; run = 0; pm_d = 0;
        void'($urandom(31));
        repeat (2) @(posedge clk);
        check(rf_gate, 1'b1);
        check(pulse_mon, 1'b0);
        rstn <= 1'b1;
        @(posedge clk);
        // Preset timing and modes, then an unmapped place
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(rd, RST_TAB[i]);
        end
        apb(1'b0, 8'h1C, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        // Manual trigger: width and the extra single delay
        w = 2 + int'($urandom % 6);
        d = 1 + int'($urandom % 5);
        g = 2 + int'($urandom % 6);
        apb(1'b1, tpgm_pkg::ADDR_WIDTH, w);
        apb(1'b1, tpgm_pkg::ADDR_DELAY, 32'h0);
        apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h12);
        fire(lat0, n);
        check(n, 1);
        check(widths[$], w);
        apb(1'b1, tpgm_pkg::ADDR_DELAY, d);
        fire(lat, n);
        check(lat - lat0, d);
        // Double pulse ignores the single delay, gap sets the spacing
        apb(1'b1, tpgm_pkg::ADDR_DBL_DELAY, g);
        apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h1A);
        fire(lat, n);
        check(n, 2);
        check(lat, lat0);
        check(rises[$] - rises[$-1], w + g);
        check(widths[$], w);
        check(widths[$-1], w);
        // Shortest pulse, both of the pair
        apb(1'b1, tpgm_pkg::ADDR_WIDTH, 32'h1);
        fire(lat, n);
        check(widths[$], 1);
        check(widths[$-1], 1);
        // Command in external and gated modes has no effect
        for (int m = 2; m < 4; m++) begin
            apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h02 | (m << 4));
            fire(lat, n);
            check(n, 0);
        end
        // Auto trigger every period, gate follows the pulse in both senses
        p = 30 + int'($urandom % 20);
        apb(1'b1, tpgm_pkg::ADDR_PERIOD, p);
        apb(1'b1, tpgm_pkg::ADDR_DELAY, 32'h0);
        apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h02);
        repeat (4 * p) @(posedge clk);
        check(rises[$] - rises[$-1], p);
        cmp_rf(1'b0, 2 * p);
        apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h06);
        cmp_rf(1'b1, 2 * p);
        // Source off keeps RF on; generator runs on with source off or external
        apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h00);
        @(posedge clk); // New gate level first sampled at this edge
        n0 = rises.size();
        c0 = tpgm_ext_src_i.rf_on_cnt;
        repeat (3 * p) @(posedge clk);
        check(tpgm_ext_src_i.rf_on_cnt - c0, 3 * p);
        check(32'(rises.size() - n0 >= 2), 32'h1);
        for (int pol = 0; pol < 2; pol++) begin
            apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h01 | (pol << 2));
            n0 = rises.size();
            for (int v = 1; v >= 0; v--) begin
                tpgm_ext_src_i.hold(v[0], 2 * p);
                check(rf_gate, v[0] ^ pol[0]);
            end
            check(32'(rises.size() - n0 >= 2), 32'h1);
        end
        // External edge trigger on the selected slope only
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h22 | (s << 6));
            n0 = rises.size();
            tpgm_ext_src_i.hold(1'b1, 40);
            check(rises.size() - n0, 1 - s);
            tpgm_ext_src_i.hold(1'b0, 40);
            check(rises.size() - n0, 1);
            tpgm_ext_src_i.edges(3);
            repeat (20) @(posedge clk);
            check(rises.size() - n0, 4);
        end
        // Gated trigger while the gate is at its active level
        for (int gi = 0; gi < 2; gi++) begin
            apb(1'b1, tpgm_pkg::ADDR_CTRL, 32'h32 | (gi << 7));
            tpgm_ext_src_i.hold(gi[0], 40);
            n0 = rises.size();
            tpgm_ext_src_i.hold(!gi[0], 10 * p);
            n = rises.size() - n0;
            check(32'(n >= 9 && n <= 11), 32'h1);
            tpgm_ext_src_i.hold(gi[0], p);
            n0 = rises.size();
            tpgm_ext_src_i.hold(gi[0], 3 * p);
            check(rises.size() - n0, 0);
            apb(1'b0, tpgm_pkg::ADDR_STATUS, 32'h0);
            check(rd, 32'h0);
        end
        report_and_stop();
    end
endmodule : tpgm_core_tb_top
